/* vcsrm_top.sv */
// Purpose: soft reset controller with per-module inhibit, APB slave
// Assumes: pclk 100 MHz, presetn asynchronous active low
// Notes:   every access takes one wait state; lane 0 lands before lane 1
//
// Functional notes
// - inhibited module stays out of reset
// - no inhibits means whole core resets
// - lower byte written before trigger byte
// - low bits 7..5 inhibit scaler, colour, brightness
// - low bits 4..2 inhibit timing, separator, converter
// - low bit 1 front end, bit 0 zero
// - trigger bit 7 is the core request
// - trigger bits 3..2 register module, formatter
// - trigger bits 1..0 copy detect, slicer
//
// The APB register port was left to the implementer.
module vcsrm_top (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // per-module reset lines
  output vcsrm_pkg::vcsrm_resets_s   module_resets
);

  // ===========================================================
  // state
  logic [7:0]                inhibit_low_q;
  logic [7:0]                inhibit_low_d;
  logic [7:0]                inhibit_high_q;
  logic [7:0]                inhibit_high_d;
  logic [31:0]               prdata_q;
  logic [31:0]               prdata_d;
  logic                      pready_q;
  logic                      pslverr_q;
  logic                      pslverr_d;
  vcsrm_pkg::vcsrm_resets_s  resets_q;
  vcsrm_pkg::vcsrm_resets_s  resets_d;

  // ===========================================================
  // bus decode: first access cycle writes lane 0, second lane 1
  wire logic addr_hit   = (paddr[11:2] == vcsrm_pkg::RESET_CTRL_ADDR[11:2]);
  wire logic access     = psel & penable;
  wire logic first_cyc  = access & ~pready_q;
  wire logic second_cyc = access & pready_q;
  wire logic wr_ok      = pwrite & addr_hit;
  wire logic wr_low     = first_cyc & wr_ok & pstrb[0];
  wire logic wr_high    = second_cyc & wr_ok & pstrb[1];
  wire logic core_req   = inhibit_high_q[vcsrm_pkg::CORE_RESET_REQUEST_BIT];

  // next register values
  // lane 0 lands one edge ahead
  assign inhibit_low_d  = wr_low
                        ? (pwdata[7:0] & vcsrm_pkg::INHIBIT_LOW_WMASK)
                        : inhibit_low_q;
  assign inhibit_high_d = wr_high ? pwdata[15:8] : inhibit_high_q;

  // read data and error, captured in the first access cycle
  // reserved bit reads zero
  assign prdata_d  = first_cyc
                   ? (addr_hit ? {16'h0000, inhibit_high_q, inhibit_low_q}
                               : 32'h0000_0000)
                   : prdata_q;
  assign pslverr_d = first_cyc & ~addr_hit;

  // request reaches a module only while its inhibit is clear
  function automatic logic gated_request(input logic req,
                                         input logic inhibit);
    return req & ~inhibit;
  endfunction

  // ===========================================================
  // reset gating: request passes only where inhibit is clear
  // inhibit blocks the request
  // all clear means all lines assert
  assign resets_d.scaler           = gated_request(core_req,
    inhibit_low_q[vcsrm_pkg::SCALER_BIT]);
  assign resets_d.colour_path      = gated_request(core_req,
    inhibit_low_q[vcsrm_pkg::COLOUR_PATH_BIT]);
  assign resets_d.brightness_path  = gated_request(core_req,
    inhibit_low_q[vcsrm_pkg::BRIGHTNESS_PATH_BIT]);
  assign resets_d.timing_generator = gated_request(core_req,
    inhibit_low_q[vcsrm_pkg::TIMING_GENERATOR_BIT]);
  assign resets_d.separator        = gated_request(core_req,
    inhibit_low_q[vcsrm_pkg::SEPARATOR_BIT]);
  assign resets_d.rate_converter   = gated_request(core_req,
    inhibit_low_q[vcsrm_pkg::RATE_CONVERTER_BIT]);
  assign resets_d.front_end        = gated_request(core_req,
    inhibit_low_q[vcsrm_pkg::FRONT_END_BIT]);
  assign resets_d.register_module  = gated_request(core_req,
    inhibit_high_q[vcsrm_pkg::REGISTER_MODULE_BIT]);
  assign resets_d.output_formatter = gated_request(core_req,
    inhibit_high_q[vcsrm_pkg::OUTPUT_FORMATTER_BIT]);
  assign resets_d.copy_protect_detect = gated_request(core_req,
    inhibit_high_q[vcsrm_pkg::COPY_PROTECT_DETECT_BIT]);
  assign resets_d.blanking_slicer  = gated_request(core_req,
    inhibit_high_q[vcsrm_pkg::BLANKING_SLICER_BIT]);

  // ===========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      inhibit_low_q  <= vcsrm_pkg::INHIBIT_LOW_RESET;
      inhibit_high_q <= vcsrm_pkg::INHIBIT_HIGH_RESET;
    end
    else
    begin
      inhibit_low_q  <= inhibit_low_d;
      inhibit_high_q <= inhibit_high_d;
    end
  end

  // bus answer and reset lines
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      resets_q  <= '0;
    end
    else
    begin
      prdata_q  <= prdata_d;
      pready_q  <= first_cyc;
      pslverr_q <= pslverr_d;
      resets_q  <= resets_d;
    end
  end

  // outputs straight from flip-flops
  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign module_resets = resets_q;

  // ===========================================================
  // assertions

  a_scaler_inhibit_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    inhibit_low_q[vcsrm_pkg::SCALER_BIT] |=> !module_resets.scaler)
    else $error("inhibited scaler saw reset");

  a_full_core_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_req && inhibit_low_q == 8'h00 && inhibit_high_q[3:0] == 4'h0)
    |=> (&module_resets))
    else $error("core reset not applied to every module");

  a_lower_byte_first: assert property (
    @(posedge pclk) disable iff (!presetn)
    (first_cyc && wr_ok && pstrb[1:0] == 2'b11)
    |=> (inhibit_low_q == ($past(pwdata[7:0]) & 8'hfe))
        && (inhibit_high_q == $past(inhibit_high_q))
    ##1 (inhibit_high_q == $past(pwdata[15:8], 2)))
    else $error("byte lanes not applied low then high");

  a_two_cycle_access: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("access did not end one wait state in");

  a_high_lane_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    (first_cyc && pstrb[1:0] == 2'h2)
    |=> (inhibit_low_q == $past(inhibit_low_q)))
    else $error("unstrobed lower byte changed");

  a_colour_inhibit_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    inhibit_low_q[vcsrm_pkg::COLOUR_PATH_BIT]
    |=> !module_resets.colour_path)
    else $error("inhibited colour path saw reset");

  a_brightness_inhibit_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    inhibit_low_q[vcsrm_pkg::BRIGHTNESS_PATH_BIT]
    |=> !module_resets.brightness_path)
    else $error("inhibited brightness path saw reset");

  a_scaler_reset_applies: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_req && !inhibit_low_q[vcsrm_pkg::SCALER_BIT])
    |=> module_resets.scaler)
    else $error("scaler reset missing");

  a_colour_reset_applies: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_req && !inhibit_low_q[vcsrm_pkg::COLOUR_PATH_BIT])
    |=> module_resets.colour_path)
    else $error("colour path reset missing");

  a_brightness_reset_applies: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_req && !inhibit_low_q[vcsrm_pkg::BRIGHTNESS_PATH_BIT])
    |=> module_resets.brightness_path)
    else $error("brightness path reset missing");

  a_timing_gen_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_req && !inhibit_low_q[vcsrm_pkg::TIMING_GENERATOR_BIT])
    |=> module_resets.timing_generator)
    else $error("timing generator reset missing");

  a_timing_inhibit_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    inhibit_low_q[vcsrm_pkg::TIMING_GENERATOR_BIT]
    |=> !module_resets.timing_generator)
    else $error("inhibited timing generator saw reset");

  a_separator_inhibit_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    inhibit_low_q[vcsrm_pkg::SEPARATOR_BIT]
    |=> !module_resets.separator)
    else $error("inhibited separator saw reset");

  a_converter_inhibit_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    inhibit_low_q[vcsrm_pkg::RATE_CONVERTER_BIT]
    |=> !module_resets.rate_converter)
    else $error("inhibited rate converter saw reset");

  a_separator_reset_applies: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_req && !inhibit_low_q[vcsrm_pkg::SEPARATOR_BIT])
    |=> module_resets.separator)
    else $error("separator reset missing");

  a_converter_reset_applies: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_req && !inhibit_low_q[vcsrm_pkg::RATE_CONVERTER_BIT])
    |=> module_resets.rate_converter)
    else $error("rate converter reset missing");

  a_reserved_reads_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready && !pwrite) |-> (prdata[0] == 1'b0 && prdata[31:16] == 16'h0))
    else $error("reserved read bits not zero");

  a_front_inhibit_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    inhibit_low_q[vcsrm_pkg::FRONT_END_BIT]
    |=> !module_resets.front_end)
    else $error("inhibited front end saw reset");

  a_front_reset_applies: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_req && !inhibit_low_q[vcsrm_pkg::FRONT_END_BIT])
    |=> module_resets.front_end)
    else $error("front end reset missing");

  a_idle_no_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    !core_req |=> (module_resets == '0))
    else $error("reset line high without request");

  a_register_mod_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_req && !inhibit_high_q[vcsrm_pkg::REGISTER_MODULE_BIT])
    |=> module_resets.register_module)
    else $error("register module reset missing");

  a_register_inhibit_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    inhibit_high_q[vcsrm_pkg::REGISTER_MODULE_BIT]
    |=> !module_resets.register_module)
    else $error("inhibited register module saw reset");

  a_formatter_inhibit_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    inhibit_high_q[vcsrm_pkg::OUTPUT_FORMATTER_BIT]
    |=> !module_resets.output_formatter)
    else $error("inhibited output formatter saw reset");

  a_formatter_reset_applies: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_req && !inhibit_high_q[vcsrm_pkg::OUTPUT_FORMATTER_BIT])
    |=> module_resets.output_formatter)
    else $error("output formatter reset missing");

  a_slicer_inhibit_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    inhibit_high_q[vcsrm_pkg::BLANKING_SLICER_BIT]
    |=> !module_resets.blanking_slicer)
    else $error("inhibited slicer saw reset");

  a_copy_inhibit_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    inhibit_high_q[vcsrm_pkg::COPY_PROTECT_DETECT_BIT]
    |=> !module_resets.copy_protect_detect)
    else $error("inhibited copy detect saw reset");

  a_copy_reset_applies: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_req && !inhibit_high_q[vcsrm_pkg::COPY_PROTECT_DETECT_BIT])
    |=> module_resets.copy_protect_detect)
    else $error("copy detect reset missing");

  a_slicer_reset_applies: assert property (
    @(posedge pclk) disable iff (!presetn)
    (core_req && !inhibit_high_q[vcsrm_pkg::BLANKING_SLICER_BIT])
    |=> module_resets.blanking_slicer)
    else $error("slicer reset missing");

  a_release_on_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(core_req) |-> ##1 (module_resets == '0) [*2])
    else $error("reset lines not released after clear");

endmodule

/* vcsrm_pkg.sv */
// Purpose: constants and carrier types for the video core soft reset block
// Assumes: 32-bit APB, one word holds both control bytes
// Notes:   byte lane 0 is the lower inhibit byte, lane 1 the trigger byte
package vcsrm_pkg;

  // ===========================================================
  // register map
  localparam logic [11:0] RESET_CTRL_ADDR = 12'h4a4;
  localparam logic [7:0]  INHIBIT_LOW_RESET  = 8'h00;
  localparam logic [7:0]  INHIBIT_HIGH_RESET = 8'h00;
  localparam logic [7:0]  INHIBIT_LOW_WMASK  = 8'hfe; // bit 0 reads zero

  // ===========================================================
  // lower inhibit byte fields
  localparam int SCALER_BIT           = 7;
  localparam int COLOUR_PATH_BIT      = 6;
  localparam int BRIGHTNESS_PATH_BIT  = 5;
  localparam int TIMING_GENERATOR_BIT = 4;
  localparam int SEPARATOR_BIT        = 3;
  localparam int RATE_CONVERTER_BIT   = 2;
  localparam int FRONT_END_BIT        = 1;

  // ===========================================================
  // trigger byte fields
  localparam int CORE_RESET_REQUEST_BIT  = 7;
  localparam int REGISTER_MODULE_BIT     = 3;
  localparam int OUTPUT_FORMATTER_BIT    = 2;
  localparam int COPY_PROTECT_DETECT_BIT = 1;
  localparam int BLANKING_SLICER_BIT     = 0;

  // ===========================================================
  // per-module reset lines, active high
  typedef struct packed {
    logic scaler;
    logic colour_path;
    logic brightness_path;
    logic timing_generator;
    logic separator;
    logic rate_converter;
    logic front_end;
    logic register_module;
    logic output_formatter;
    logic copy_protect_detect;
    logic blanking_slicer;
  } vcsrm_resets_s;

endpackage

/* vcsrm_top_bench.sv */
// Purpose: self-checking bench for the soft reset controller
// Assumes: apb slave answers with pready, reset lines registered
// Notes:   walks every inhibit bit and the byte staging order
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("[FAIL] %0t got %h expected %h", $time, g, e); \
    end \
  end
module vcsrm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ===========================================================
  // signals
  logic                     pclk = 1'b0;
  logic                     presetn = 1'b0;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [11:0]              paddr = 12'h000;
  logic [31:0]              pwdata = 32'h0;
  logic [3:0]               pstrb = 4'h0;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  vcsrm_pkg::vcsrm_resets_s module_resets;
  logic [31:0]              rd;
  logic                     er;
  logic [10:0]              m;
  logic [7:0]               lo;
  logic [7:0]               hi;
  int                       mismatches = 0;
  int                       total_checks = 0;
  int                       cycles = 0;
  // design under test
  vcsrm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .module_resets(module_resets));
  // ===========================================================
  // clock and watchdog
  always #5 pclk = ~pclk;
  // cut a hang short
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      finish_test();
    end
  end
  // ===========================================================
  // helpers
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one apb transfer, held until pready
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected reset lines from both control bytes
  function automatic vcsrm_pkg::vcsrm_resets_s exp_res(logic [7:0] l,
                                                       logic [7:0] h);
    return h[7] ? ~{l[7:1], h[3:0]} : 11'h000;
  endfunction
  // ===========================================================
  // tests
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 12'h4a4, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_0000);
    `CHK(module_resets, 11'h000);
    // request with no inhibits, held level
    xfer(1'b1, 12'h4a4, 32'h0000_8000, 4'h3);
    @(posedge pclk);
    repeat (5)
    begin
      #1 `CHK(module_resets, 11'h7ff);
      @(posedge pclk);
    end
    xfer(1'b1, 12'h4a4, 32'h0, 4'h2);
    $display("test whole_core done");
    // walk one inhibit bit at a time
    for (int i = 0; i < 11; i++)
    begin
      m = 11'h001 << i;
      lo = {m[10:4], 1'b0};
      hi = {4'h8, m[3:0]};
      xfer(1'b1, 12'h4a4, {16'h0, hi & 8'h0f, lo}, 4'h3);
      xfer(1'b1, 12'h4a4, {16'h0, hi, 8'hff}, 4'h2);
      @(posedge pclk);
      #1 `CHK(module_resets, exp_res(lo, hi));
      xfer(1'b0, 12'h4a4, 32'h0, 4'h0);
      `CHK(rd, {16'h0, hi, lo});
      xfer(1'b1, 12'h4a4, {16'h0, hi & 8'h0f, lo}, 4'h2);
      @(posedge pclk);
      #1 `CHK(module_resets, 11'h000);
    end
    $display("test inhibit_walk done");
    // reserved bit, then clear both bytes in one write
    xfer(1'b1, 12'h4a4, 32'h0000_0fff, 4'h3);
    xfer(1'b0, 12'h4a4, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_0ffe);
    xfer(1'b1, 12'h4a4, 32'h0000_8f00, 4'h2);
    @(posedge pclk);
    #1 `CHK(module_resets, 11'h000);
    xfer(1'b1, 12'h4a4, 32'h0, 4'h3);
    #1 `CHK(module_resets, 11'h7f0);
    @(posedge pclk);
    #1 `CHK(module_resets, 11'h000);
    $display("test byte_order done");
    // unmapped word is refused and changes nothing
    xfer(1'b1, 12'h4a8, 32'h0000_ffff, 4'hf);
    `CHK(er, 1'b1);
    xfer(1'b0, 12'h4a8, 32'h0, 4'h0);
    `CHK(rd, 32'h0);
    xfer(1'b0, 12'h4a4, 32'h0, 4'h0);
    `CHK(rd, 32'h0);
    `CHK(module_resets, 11'h000);
    $display("test unmapped done");
    // mid-run reset clears a standing request
    xfer(1'b1, 12'h4a4, 32'h0000_8000, 4'h2);
    @(posedge pclk);
    #1 `CHK(module_resets, 11'h7ff);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1 `CHK(module_resets, 11'h000);
    @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 12'h4a4, 32'h0, 4'h0);
    `CHK(rd, 32'h0);
    `CHK(er, 1'b0);
    $display("test mid_reset done");
    finish_test();
  end
endmodule
